/* File: hdl/ddrmc_map.vh */
`ifndef DDRMC_MAP_VH
`define DDRMC_MAP_VH
// ==========================================================
// register byte offsets
`define DDRMC_OFF_MAIN_CFG 12'h000
`define DDRMC_OFF_CFG_TWO 12'h004
`define DDRMC_OFF_MODE 12'h008
`define DDRMC_OFF_EXT_MODE 12'h00c
`define DDRMC_OFF_CMD_CTRL 12'h010
`define DDRMC_OFF_INIT_DATA 12'h014
`define DDRMC_OFF_STATUS 12'h018
// ==========================================================
// main config fields (bit positions, lsb = 0)
`define DDRMC_MEM_EN_BIT 31
`define DDRMC_SLEEP_REF_BIT 30
// ==========================================================
// config two fields
`define DDRMC_FORCE_SELF_REFRESH_BIT 31
`define DDRMC_PANIC_EN_BIT 30
`define DDRMC_DLL_DIS_BIT 29
`define DDRMC_STROBE_HI 27
`define DDRMC_STROBE_LO 26
`define DDRMC_ODT_HI 22
`define DDRMC_ODT_LO 21
`define DDRMC_NPR_HI 15
`define DDRMC_NPR_LO 12
`define DDRMC_DINIT_BIT 4
// ==========================================================
// command control fields
`define DDRMC_MRS_BIT 31
`define DDRMC_CS_HI 29
`define DDRMC_CS_LO 28
`define DDRMC_BSEL_HI 26
`define DDRMC_BSEL_LO 24
`define DDRMC_SREF_BIT 23
`define DDRMC_SPRE_BIT 22
`define DDRMC_CKEF_HI 21
`define DDRMC_CKEF_LO 20
`define DDRMC_PRE_ALL_BIT 10
`define DDRMC_DLL_RST_BIT 8
// ==========================================================
// reset values and codes
`define DDRMC_RST_WORD 32'h0000_1000
`define DDRMC_RST_ZERO 32'h0000_0000
`define DDRMC_NPR_ONE 4'h1
`define DDRMC_NPR_THREE 4'h3
`define DDRMC_NPR_EIGHT 4'h8
`define DDRMC_CKE_LOW 2'h1
`define DDRMC_CKE_HIGH 2'h2
`define DDRMC_ODT_WR 2'h1
`define DDRMC_ODT_RD 2'h2
`define DDRMC_ODT_ON 2'h3
`define DDRMC_BA_MR 3'h0
`define DDRMC_BA_EMR 3'h1
`define DDRMC_BA_EMR2 3'h2
`define DDRMC_BA_EMR3 3'h3
// ==========================================================
// sdram commands {ras_n, cas_n, we_n}
`define DDRMC_CMD_NOP 3'h7
`define DDRMC_CMD_MRS 3'h0
`define DDRMC_CMD_REF 3'h1
`define DDRMC_CMD_PRE 3'h2
// ==========================================================
// timing counts
`define DDRMC_INIT_WORDS 16384
`define DDRMC_INIT_STEPS 3'h6
`endif

/* File: hdl/ddrmc_sync.v */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two-stage level synchroniser
module ddrmc_sync (
	input wire pclk, // clock
	input wire presetn, // async reset, active low
	input wire async_in, // level from another domain
	output reg sync_out // synchronised level
);
	reg meta;
	// first stage feeds only the second
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule // ddrmc_sync
`default_nettype wire

/* File: hdl/ddrmc_init_engine.v */
`timescale 1ns/1ps
`default_nettype none
`include "ddrmc_map.vh"
// ==========================================================
// writes a pattern word to every memory location
module ddrmc_init_engine #(
	parameter INIT_WORDS = `DDRMC_INIT_WORDS // words to fill
) (
	input wire pclk, // clock
	input wire presetn, // async reset, active low
	input wire start, // one-cycle start pulse
	input wire [31:0] pattern, // fill value
	output reg wr_valid, // write request to datapath
	output reg [15:0] wr_addr, // word address
	output reg [31:0] wr_data, // write data
	input wire wr_ready, // datapath accepts write
	output reg done // one-cycle completion pulse
);
	localparam [31:0] LAST_WIDE = INIT_WORDS - 1; // only 16 address bits used
	localparam [15:0] LAST = LAST_WIDE[15:0];
	// step through addresses, holding each until accepted
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_valid <= 1'b0;
			wr_addr <= 16'h0000;
			wr_data <= 32'h0000_0000;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !wr_valid) begin
				wr_valid <= 1'b1;
				wr_addr <= 16'h0000;
				wr_data <= pattern;
			end else if (wr_valid && wr_ready) begin
				if (wr_addr == LAST) begin
					wr_valid <= 1'b0;
					done <= 1'b1;
				end else begin
					wr_addr <= wr_addr + 16'h0001;
				end
			end
		end
	end
endmodule // ddrmc_init_engine
`default_nettype wire

/* File: hdl/ddrmc_top.v */
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "ddrmc_map.vh"
module ddrmc_top #(
	parameter INIT_WORDS = `DDRMC_INIT_WORDS // words filled by data init
) (
	input wire pclk, // 100 MHz clock
	input wire presetn, // async reset, active low
	input wire psel, // apb select
	input wire penable, // apb enable
	input wire pwrite, // apb direction
	input wire [11:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output reg pready, // apb ready
	output reg pslverr, // apb error, unmapped address
	input wire panic_refresh_request, // async panic pin
	input wire mem_read_active, // datapath reading dram
	output reg [3:0] chip_select_n, // sdram chip selects
	output reg ras_n, // sdram row strobe
	output reg cas_n, // sdram column strobe
	output reg we_n, // sdram write enable
	output reg [2:0] bank_address_pins, // sdram bank address
	output reg [15:0] memory_address_pins, // sdram address
	output reg cke, // sdram clock enable
	output reg odt, // internal termination enable
	output reg strobe_true_only, // true strobes selected
	output wire init_wr_valid, // data init write request, engine flop
	output wire [15:0] init_wr_addr, // data init address, engine flop
	output wire [31:0] init_wr_data, // data init pattern, engine flop
	input wire init_wr_ready // datapath accepts write
);
	// ==========================================================
	// state codes
	localparam [2:0] ST_OFF = 3'h0;
	localparam [2:0] ST_INIT = 3'h1;
	localparam [2:0] ST_IDLE = 3'h2;
	localparam [2:0] ST_REF = 3'h3;
	localparam [2:0] ST_SREF = 3'h4;
	localparam [2:0] ST_DINIT = 3'h5;
	reg [2:0] state;
	reg [2:0] step;
	reg [3:0] ref_left;
	reg gap;
	reg mem_en;
	reg sleep_ref_en;
	reg [31:0] cfg_two;
	reg [31:0] mode_vals;
	reg [31:0] ext_vals;
	reg [31:0] cmd_ctrl;
	reg [31:0] init_pattern;
	reg dinit_start;
	wire panic_sync;
	wire dinit_done;

	// ==========================================================
	// chip select decode, active low
	function [3:0] cs_decode;
		input [1:0] sel;
		begin
			cs_decode = ~(4'h1 << sel);
		end
	endfunction
	// posted refresh count, reserved codes give one
	function [3:0] npr_count;
		input [3:0] code;
		begin
			if ((code >= `DDRMC_NPR_ONE && code <= `DDRMC_NPR_THREE) ||
				code == `DDRMC_NPR_EIGHT) begin
				npr_count = code;
			end else begin
				npr_count = `DDRMC_NPR_ONE;
			end
		end
	endfunction

	// ==========================================================
	// field views
	wire force_self_refresh = cfg_two[`DDRMC_FORCE_SELF_REFRESH_BIT];
	wire panic_en = cfg_two[`DDRMC_PANIC_EN_BIT];
	wire dll_dis = cfg_two[`DDRMC_DLL_DIS_BIT];
	wire [1:0] termination_config = cfg_two[`DDRMC_ODT_HI:`DDRMC_ODT_LO];
	wire [3:0] npr = cfg_two[`DDRMC_NPR_HI:`DDRMC_NPR_LO];
	wire dinit_pend = cfg_two[`DDRMC_DINIT_BIT];
	wire [1:0] cs_sel = cmd_ctrl[`DDRMC_CS_HI:`DDRMC_CS_LO];
	wire [2:0] bsel = cmd_ctrl[`DDRMC_BSEL_HI:`DDRMC_BSEL_LO];
	wire [1:0] cke_force = cmd_ctrl[`DDRMC_CKEF_HI:`DDRMC_CKEF_LO];
	wire [15:0] cmd_value = cmd_ctrl[15:0];
	wire [15:0] base_mode_value = mode_vals[15:0];
	wire [15:0] ext_mode_value = mode_vals[31:16];
	wire [15:0] ext_mode2_value = ext_vals[31:16];
	wire [15:0] ext_mode3_value = ext_vals[15:0];
	wire sref_req = force_self_refresh || (panic_en && panic_sync);
	wire acc = psel && penable && pready;
	wire wr_acc = acc && pwrite;
	wire rd_setup = psel && !penable;
	wire issue_ok = mem_en && state == ST_IDLE && !gap && !sref_req && // idle may issue
		!(dinit_pend && !init_wr_valid);
	wire [2:0] trig = cmd_ctrl[`DDRMC_MRS_BIT] ? 3'h4 :
		cmd_ctrl[`DDRMC_SREF_BIT] ? 3'h2 : {2'h0, cmd_ctrl[`DDRMC_SPRE_BIT]};
	wire [31:0] trig_clr = issue_ok ? {trig[2], 7'h0, trig[1:0], 22'h0} : 32'h0;

	// ==========================================================
	// panic pin synchroniser and data init engine
	ddrmc_sync u_panic_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(panic_refresh_request),
		.sync_out(panic_sync)
	);

	ddrmc_init_engine #(
		.INIT_WORDS(INIT_WORDS)
	) u_init_engine (
		.pclk(pclk),
		.presetn(presetn),
		.start(dinit_start),
		.pattern(init_pattern),
		.wr_valid(init_wr_valid), // handshake seen by the pins
		.wr_addr(init_wr_addr),
		.wr_data(init_wr_data),
		.wr_ready(init_wr_ready),
		.done(dinit_done)
	);

	// ==========================================================
	// apb response, zero wait states
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= rd_setup;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (rd_setup) begin
				case (paddr)
					`DDRMC_OFF_MAIN_CFG: prdata <= {mem_en, sleep_ref_en, 30'h0};
					`DDRMC_OFF_CFG_TWO: prdata <= cfg_two;
					`DDRMC_OFF_MODE: prdata <= mode_vals;
					`DDRMC_OFF_EXT_MODE: prdata <= ext_vals;
					`DDRMC_OFF_CMD_CTRL: prdata <= cmd_ctrl;
					`DDRMC_OFF_INIT_DATA: prdata <= init_pattern;
					`DDRMC_OFF_STATUS: prdata <= {24'h0, cke, odt, 3'h0, state};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// ==========================================================
	// register writes; hardware clears lose to software sets
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_en <= 1'b0;
			sleep_ref_en <= 1'b0;
			cfg_two <= `DDRMC_RST_WORD;
			mode_vals <= `DDRMC_RST_ZERO;
			ext_vals <= `DDRMC_RST_ZERO;
			cmd_ctrl <= `DDRMC_RST_ZERO;
			init_pattern <= `DDRMC_RST_ZERO;
		end else begin
			if (dinit_done) begin
				cfg_two[`DDRMC_DINIT_BIT] <= 1'b0;
			end
			cmd_ctrl <= cmd_ctrl & ~trig_clr;
			if (wr_acc) begin
				case (paddr)
					`DDRMC_OFF_MAIN_CFG: begin
						mem_en <= pwdata[`DDRMC_MEM_EN_BIT];
						sleep_ref_en <= pwdata[`DDRMC_SLEEP_REF_BIT];
					end
					`DDRMC_OFF_CFG_TWO: begin
						cfg_two <= (pwdata & 32'hec60_f010) |
							(cfg_two & {27'h0, !dinit_done, 4'h0});
					end
					`DDRMC_OFF_MODE: mode_vals <= pwdata;
					`DDRMC_OFF_EXT_MODE: ext_vals <= pwdata;
					`DDRMC_OFF_CMD_CTRL: begin
						cmd_ctrl <= (pwdata & 32'h37b0_ffff) |
							(cmd_ctrl & ~trig_clr & 32'h80c0_0000) |
							(pwdata & 32'h80c0_0000);
					end
					`DDRMC_OFF_INIT_DATA: init_pattern <= pwdata;
					default: ;
				endcase
			end
		end
	end

	// ==========================================================
	// sdram command sequencer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_OFF;
			step <= 3'h0;
			ref_left <= 4'h0;
			gap <= 1'b0;
			dinit_start <= 1'b0;
			chip_select_n <= 4'hf;
			{ras_n, cas_n, we_n} <= `DDRMC_CMD_NOP;
			bank_address_pins <= 3'h0;
			memory_address_pins <= 16'h0000;
			cke <= 1'b0;
		end else begin
			chip_select_n <= 4'hf;
			{ras_n, cas_n, we_n} <= `DDRMC_CMD_NOP;
			dinit_start <= 1'b0;
			gap <= 1'b0;
			if (!gap) begin
				case (state)
					ST_OFF: begin
						if (mem_en) begin
							cke <= 1'b1;
							step <= 3'h0;
							state <= ST_INIT;
						end
					end
					ST_INIT: begin
						// precharge all, then ext2, ext3, ext, mode with and without DLL reset
						gap <= 1'b1;
						chip_select_n <= 4'h0;
						{ras_n, cas_n, we_n} <= `DDRMC_CMD_MRS;
						step <= step + 3'h1;
						case (step)
							3'h0: begin
								{ras_n, cas_n, we_n} <= `DDRMC_CMD_PRE;
								memory_address_pins <= 16'h0400;
							end
							3'h1: begin
								bank_address_pins <= `DDRMC_BA_EMR2;
								memory_address_pins <= ext_mode2_value;
							end
							3'h2: begin
								bank_address_pins <= `DDRMC_BA_EMR3;
								memory_address_pins <= ext_mode3_value;
							end
							3'h3: begin
								bank_address_pins <= `DDRMC_BA_EMR;
								memory_address_pins <= ext_mode_value;
							end
							3'h4: begin
								bank_address_pins <= `DDRMC_BA_MR;
								memory_address_pins <= base_mode_value | 16'h0100;
							end
							default: begin
								bank_address_pins <= `DDRMC_BA_MR;
								memory_address_pins <= base_mode_value & 16'hfeff;
								state <= ST_IDLE;
							end
						endcase
					end
					ST_IDLE: begin
						if (!mem_en) begin
							state <= ST_OFF;
						end else if (sref_req) begin
							// self-refresh entry: refresh with cke low
							chip_select_n <= 4'h0;
							{ras_n, cas_n, we_n} <= `DDRMC_CMD_REF;
							cke <= 1'b0;
							gap <= 1'b1;
							state <= ST_SREF;
						end else if (dinit_pend && !init_wr_valid) begin
							dinit_start <= 1'b1;
							state <= ST_DINIT;
						end else if (cmd_ctrl[`DDRMC_MRS_BIT]) begin
							chip_select_n <= cs_decode(cs_sel);
							{ras_n, cas_n, we_n} <= `DDRMC_CMD_MRS;
							bank_address_pins <= bsel;
							memory_address_pins <= cmd_value;
							gap <= 1'b1;
						end else if (cmd_ctrl[`DDRMC_SREF_BIT]) begin
							ref_left <= npr_count(npr);
							state <= ST_REF;
						end else if (cmd_ctrl[`DDRMC_SPRE_BIT]) begin
							chip_select_n <= cs_decode(cs_sel);
							{ras_n, cas_n, we_n} <= `DDRMC_CMD_PRE;
							bank_address_pins <= bsel;
							memory_address_pins <= {5'h0, cmd_value[`DDRMC_PRE_ALL_BIT], 10'h0};
							gap <= 1'b1;
						end
					end
					ST_REF: begin
						// posted refreshes, one NOP cycle between each
						chip_select_n <= cs_decode(cs_sel);
						{ras_n, cas_n, we_n} <= `DDRMC_CMD_REF;
						ref_left <= ref_left - 4'h1;
						gap <= 1'b1;
						if (ref_left == 4'h1) begin
							state <= ST_IDLE;
						end
					end
					ST_SREF: begin
						if (!sref_req) begin
							cke <= 1'b1;
							gap <= 1'b1;
							state <= ST_IDLE;
							if (!dll_dis) begin
								// exit with DLL reset via mode register
								chip_select_n <= 4'h0;
								{ras_n, cas_n, we_n} <= `DDRMC_CMD_MRS;
								bank_address_pins <= `DDRMC_BA_MR;
								memory_address_pins <= base_mode_value | 16'h0100;
							end
						end
					end
					ST_DINIT: begin
						if (dinit_done) begin
							state <= ST_IDLE;
						end
					end
					default: state <= ST_OFF;
				endcase
			end
			// software force overrides, level kept after clear
			if (cke_force == `DDRMC_CKE_LOW) begin
				cke <= 1'b0;
			end else if (cke_force == `DDRMC_CKE_HIGH) begin
				cke <= 1'b1;
			end
		end
	end

	// ==========================================================
	// termination and strobe mode outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			odt <= 1'b0;
			strobe_true_only <= 1'b1;
		end else begin
			strobe_true_only <= (cfg_two[`DDRMC_STROBE_HI:`DDRMC_STROBE_LO] == 2'h0);
			case (termination_config)
				`DDRMC_ODT_WR: odt <= init_wr_valid;
				`DDRMC_ODT_RD: odt <= mem_read_active;
				`DDRMC_ODT_ON: odt <= 1'b1;
				default: odt <= 1'b0;
			endcase
		end
	end
endmodule // ddrmc_top
`default_nettype wire

/* File: dv/ddrmc_sdram_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// sdram side: logs commands, accepts init writes with stalls
module ddrmc_sdram_model (
	input wire logic clk, // memory clock
	input wire logic rst_n, // reset, active low
	input wire logic [3:0] cs_n, // chip selects
	input wire logic [2:0] cmd, // ras, cas, we
	input wire logic [2:0] ba, // bank address
	input wire logic [15:0] addr, // address pins
	input wire logic cke, // clock enable
	input wire logic wr_valid, // init write request
	input wire logic [31:0] wr_data, // init write data
	output logic wr_ready // init write accept
);
	logic [26:0] cmd_log [0:127];
	logic [31:0] last_wr;
	int n_cmd;
	int n_wr;
	// log each selected command; accept every other cycle only
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			n_cmd <= 0;
			n_wr <= 0;
			wr_ready <= 1'b0;
		end else begin
			if (cs_n != 4'hf) begin
				cmd_log[n_cmd[6:0]] <= {cke, cs_n, cmd, ba, addr};
				n_cmd <= n_cmd + 1;
			end
			if (wr_valid && wr_ready) begin
				n_wr <= n_wr + 1;
				last_wr <= wr_data;
			end
			wr_ready <= wr_valid && !wr_ready;
		end
	end
endmodule // ddrmc_sdram_model
`default_nettype wire

/* File: dv/ddrmc_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ddrmc_map.vh"
// ==========================================================
// port checks of the mode and command block
module ddrmc_checker (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic [3:0] chip_select_n, // chip selects
	input wire logic cke, // clock enable
	input wire logic odt, // termination
	input wire logic strobe_true_only, // strobe mode
	input wire logic init_wr_valid, // init write
	input wire logic [31:0] init_wr_data, // init data
	input wire logic init_wr_ready // init accept
);
	logic wr;
	logic sh_en;
	logic [1:0] sh_dqs, sh_odt, sh_ckef;
	logic [31:0] sh_pat;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign wr = psel && penable && pready && pwrite;
	// shadow of fields software last wrote
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_en <= 1'b0;
			sh_dqs <= 2'h0;
			sh_odt <= 2'h0;
			sh_ckef <= 2'h0;
			sh_pat <= 32'h0;
		end else if (wr) begin
			if (paddr == `DDRMC_OFF_MAIN_CFG)
				sh_en <= pwdata[`DDRMC_MEM_EN_BIT];
			if (paddr == `DDRMC_OFF_CFG_TWO) begin
				sh_dqs <= pwdata[`DDRMC_STROBE_HI:`DDRMC_STROBE_LO];
				sh_odt <= pwdata[`DDRMC_ODT_HI:`DDRMC_ODT_LO];
			end
			if (paddr == `DDRMC_OFF_CMD_CTRL)
				sh_ckef <= pwdata[`DDRMC_CKEF_HI:`DDRMC_CKEF_LO];
			if (paddr == `DDRMC_OFF_INIT_DATA)
				sh_pat <= pwdata;
		end
	end
	a_ready_next: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_err_unmapped: assert property (psel && !penable && paddr > `DDRMC_OFF_STATUS |=> pslverr)
		else $error("unmapped access not refused");
	a_cmd_enabled: assert property (chip_select_n != 4'hf |-> sh_en)
		else $error("command while disabled");
	a_cmd_gap: assert property (chip_select_n != 4'hf |=> chip_select_n == 4'hf)
		else $error("commands back to back");
	a_strobe_sel: assert property ($stable(sh_dqs) [*3] |-> strobe_true_only == (sh_dqs == 2'h0))
		else $error("strobe mode wrong");
	a_odt_always: assert property (sh_odt == 2'h3 [*3] |-> odt)
		else $error("termination not on");
	a_odt_never: assert property (sh_odt == 2'h0 [*3] |-> !odt)
		else $error("termination not off");
	a_cke_low: assert property (sh_ckef == 2'h1 [*3] |-> !cke)
		else $error("cke not forced low");
	a_cke_high: assert property (sh_ckef == 2'h2 [*3] |-> cke)
		else $error("cke not forced high");
	a_init_pat: assert property (init_wr_valid |-> init_wr_data == sh_pat && sh_en)
		else $error("init write data wrong");
	a_init_hold: assert property (init_wr_valid && !init_wr_ready |=> init_wr_valid && $stable(init_wr_data))
		else $error("init write dropped");
endmodule // ddrmc_checker
`default_nettype wire

/* File: dv/ddrmc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ddrmc_map.vh"
// ==========================================================
// bench: apb register traffic, commands logged by the model
module ddrmc_top_tb;
	localparam logic [26:0] MC = 27'h038_0000, MK = 27'h438_0000, MB = 27'h03f_ffff;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic panic = 1'b0, mrd = 1'b0, pready, pslverr, re, ras_n, cas_n, we_n, cke, odt, sto, iv, ir;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rq, id;
	logic [3:0] csn;
	logic [2:0] ba;
	logic [15:0] ma, ia;
	int fail_count = 0, total_checks = 0, cyc = 0, nc = 0;
	ddrmc_top #(.INIT_WORDS(4)) ddrmc_top_i (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .panic_refresh_request(panic),
		.mem_read_active(mrd), .chip_select_n(csn), .ras_n, .cas_n, .we_n,
		.bank_address_pins(ba), .memory_address_pins(ma), .cke, .odt, .strobe_true_only(sto),
		.init_wr_valid(iv), .init_wr_addr(ia), .init_wr_data(id), .init_wr_ready(ir));
	ddrmc_sdram_model sdram (.clk(pclk), .rst_n(presetn), .cs_n(csn), .cmd({ras_n, cas_n, we_n}),
		.ba(ba), .addr(ma), .cke(cke), .wr_valid(iv), .wr_data(id), .wr_ready(ir));
	always #5 pclk = ~pclk;
	// ==========================================================
	// shared tasks
	task automatic check(input string s, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [26:0] ent(input logic k, input logic [3:0] c, input logic [2:0] m,
		input logic [2:0] b, input logic [15:0] a);
		return {k, c, m, b, a};
	endfunction
	task automatic wait_cmds(input int n);
		for (int k = 0; k < 600 && sdram.n_cmd < n; k++)
			@(posedge pclk);
		check("command count", n, sdram.n_cmd);
	endtask
	task automatic exp_cmd(input logic [26:0] e, input logic [26:0] mk);
		check("command", {5'h0, e & mk}, {5'h0, sdram.cmd_log[nc] & mk});
		nc++;
	endtask
	task automatic end_sim;
		if (fail_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_init;
		apb(1'b0, `DDRMC_OFF_CFG_TWO, 32'h0);
		check("cfg two reset", `DDRMC_RST_WORD, rq);
		apb(1'b1, 12'h100, 32'h1);
		check("unmapped error", 32'h1, {31'h0, re});
		apb(1'b1, `DDRMC_OFF_MODE, 32'h0044_0132);
		apb(1'b1, `DDRMC_OFF_EXT_MODE, 32'h0080_0005);
		apb(1'b1, `DDRMC_OFF_INIT_DATA, 32'h5a5a_c3c3);
		apb(1'b1, `DDRMC_OFF_CFG_TWO, 32'h0000_1010);
		repeat (20) @(posedge pclk);
		check("init before enable", 32'h0, sdram.n_wr);
		apb(1'b1, `DDRMC_OFF_MAIN_CFG, 32'hc000_0000);
		wait_cmds(6);
		exp_cmd(ent(1'b0, 4'h0, `DDRMC_CMD_PRE, 3'h0, 16'h0400), MC | 27'h400);
		exp_cmd(ent(1'b0, 4'h0, `DDRMC_CMD_MRS, 3'h2, 16'h0080), MB);
		exp_cmd(ent(1'b0, 4'h0, `DDRMC_CMD_MRS, 3'h3, 16'h0005), MB);
		exp_cmd(ent(1'b0, 4'h0, `DDRMC_CMD_MRS, 3'h1, 16'h0044), MB);
		exp_cmd(ent(1'b0, 4'h0, `DDRMC_CMD_MRS, 3'h0, 16'h0132), MB);
		exp_cmd(ent(1'b0, 4'h0, `DDRMC_CMD_MRS, 3'h0, 16'h0032), MB);
		for (int k = 0; k < 200 && sdram.n_wr < 4; k++)
			@(posedge pclk);
		check("init words", 32'h4, sdram.n_wr);
		check("init pattern", 32'h5a5a_c3c3, sdram.last_wr);
		check("init last address", 32'h3, {16'h0, ia});
		apb(1'b0, `DDRMC_OFF_CFG_TWO, 32'h0);
		check("init bit cleared", `DDRMC_RST_WORD, rq);
	endtask
	task automatic t_cmds;
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, `DDRMC_OFF_CMD_CTRL, 32'h0080_0000 | (c << 28));
			wait_cmds(nc + 1);
			exp_cmd(ent(1'b1, ~(4'h1 << c), `DDRMC_CMD_REF, 3'h0, 16'h0), MK | 27'h3c0_0000);
			apb(1'b0, `DDRMC_OFF_CMD_CTRL, 32'h0);
			check("refresh bit", 32'h0, rq & 32'h0080_0000);
			apb(1'b1, `DDRMC_OFF_CMD_CTRL, 32'h9000_0a00 | (c << 24) | c);
			wait_cmds(nc + 1);
			exp_cmd(ent(1'b1, 4'hd, `DDRMC_CMD_MRS, c[2:0], 16'h0a00 | c[15:0]), 27'h7ff_ffff);
			apb(1'b0, `DDRMC_OFF_CMD_CTRL, 32'h0);
			check("mode bit", 32'h0, rq & 32'h8000_0000);
		end
		for (int p = 0; p < 2; p++) begin
			apb(1'b1, `DDRMC_OFF_CFG_TWO, p ? 32'h8000 : 32'h3000);
			apb(1'b1, `DDRMC_OFF_CMD_CTRL, 32'h0080_0000);
			repeat (80) @(posedge pclk);
			nc = nc + (p ? 8 : 3);
			check("posted refreshes", nc, sdram.n_cmd);
		end
		apb(1'b1, `DDRMC_OFF_CMD_CTRL, 32'h2540_0000);
		wait_cmds(nc + 1);
		exp_cmd(ent(1'b1, 4'hb, `DDRMC_CMD_PRE, 3'h5, 16'h0), 27'h7ff_0400);
		apb(1'b1, `DDRMC_OFF_CMD_CTRL, 32'h3040_0400);
		wait_cmds(nc + 1);
		exp_cmd(ent(1'b1, 4'h7, `DDRMC_CMD_PRE, 3'h0, 16'h0400), 27'h7f8_0400);
	endtask
	task automatic t_pins;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `DDRMC_OFF_CMD_CTRL, {10'h0, i == 2, i == 0, 20'h0});
			repeat (4) @(posedge pclk);
			check("cke level", {31'h0, i > 1}, {31'h0, cke});
		end
		for (int i = 0; i < 8; i++) begin
			mrd <= i[0];
			apb(1'b1, `DDRMC_OFF_CFG_TWO, 32'h1000 | (i[2:1] << 21) | (i[0] << 26));
			repeat (4) @(posedge pclk);
			check("odt", {31'h0, i > 5 || i == 5}, {31'h0, odt});
			check("strobe mode", {31'h0, !i[0]}, {31'h0, sto});
		end
		mrd <= 1'b0;
	endtask
	task automatic t_sref;
		for (int d = 0; d < 2; d++) begin
			apb(1'b1, `DDRMC_OFF_CFG_TWO, 32'h8000_1000 | (d << 29));
			wait_cmds(nc + 1);
			exp_cmd(ent(1'b0, 4'h0, `DDRMC_CMD_REF, 3'h0, 16'h0), MK);
			apb(1'b1, `DDRMC_OFF_CFG_TWO, 32'h1000 | (d << 29));
			repeat (40) @(posedge pclk);
			check("exit commands", nc + 1 - d, sdram.n_cmd);
			if (d == 0)
				exp_cmd(ent(1'b1, 4'h0, `DDRMC_CMD_MRS, 3'h0, 16'h0100), MK | 27'h7_0100);
			check("cke after exit", 32'h1, {31'h0, cke});
		end
		apb(1'b1, `DDRMC_OFF_CFG_TWO, 32'h1000);
		panic <= 1'b1;
		repeat (30) @(posedge pclk);
		check("panic ignored", nc, sdram.n_cmd);
		apb(1'b1, `DDRMC_OFF_CFG_TWO, 32'h4000_1000);
		wait_cmds(nc + 1);
		exp_cmd(ent(1'b0, 4'h0, `DDRMC_CMD_REF, 3'h0, 16'h0), MK);
		panic <= 1'b0;
		wait_cmds(nc + 1);
		exp_cmd(ent(1'b1, 4'h0, `DDRMC_CMD_MRS, 3'h0, 16'h0100), MK | 27'h7_0100);
	endtask
	// ==========================================================
	// cycle ceiling against a hung handshake
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			end_sim();
		end
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_init();
		t_cmds();
		t_pins();
		t_sref();
		end_sim();
	end
endmodule // ddrmc_top_tb
bind ddrmc_top ddrmc_checker ddrmc_checker_i (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .pslverr, .chip_select_n, .cke, .odt, .strobe_true_only,
	.init_wr_valid, .init_wr_data, .init_wr_ready);
`default_nettype wire
